// ---- rtl/cafs_alu.sv ----
`timescale 1ns/100ps
module cafs_alu (
	// Operation
	input logic [4:0] i_op,
	input logic [2:0] i_bit,
	// Operands
	input logic [7:0] i_a,
	input logic [7:0] i_b,
	input logic [7:0] i_flags,
	// Result
	output logic [7:0] o_res,
	output logic [7:0] o_res_hi,
	output logic [7:0] o_flags,
	output logic [7:0] o_mask
);
	logic [8:0] sum;
	logic [15:0] prod;
	logic cin;
	logic is_sub;
	logic zero;

	always_comb begin
		is_sub = (i_op == cafs_pkg::ALU_SUB) | (i_op == cafs_pkg::ALU_SBC);
		cin = i_flags[cafs_pkg::FL_C] &
			((i_op == cafs_pkg::ALU_ADC) | (i_op == cafs_pkg::ALU_SBC));
		if (is_sub) begin
			sum = {1'b0, i_a} - {1'b0, i_b} - {8'h00, cin};
		end else begin
			sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin};
		end
		prod = i_a * i_b;
		o_res = i_a;
		o_res_hi = 8'h00;
		o_flags = i_flags;
		o_mask = 8'h00;
		case (i_op)
		cafs_pkg::ALU_ADD, cafs_pkg::ALU_ADC: begin
			o_res = sum[7:0];
			o_flags[cafs_pkg::FL_C] = sum[8];
			o_flags[cafs_pkg::FL_H] = (i_a[3] & i_b[3]) |
				(i_b[3] & ~sum[3]) | (~sum[3] & i_a[3]);
			o_flags[cafs_pkg::FL_V] = (i_a[7] & i_b[7] & ~sum[7]) |
				(~i_a[7] & ~i_b[7] & sum[7]);
			o_mask = cafs_pkg::MASK_ARITH;
		end
		cafs_pkg::ALU_SUB, cafs_pkg::ALU_SBC: begin
			o_res = sum[7:0];
			o_flags[cafs_pkg::FL_C] = sum[8];
			o_flags[cafs_pkg::FL_H] = (~i_a[3] & i_b[3]) |
				(i_b[3] & sum[3]) | (sum[3] & ~i_a[3]);
			o_flags[cafs_pkg::FL_V] = (i_a[7] & ~i_b[7] & ~sum[7]) |
				(~i_a[7] & i_b[7] & sum[7]);
			o_mask = cafs_pkg::MASK_ARITH;
		end
		cafs_pkg::ALU_AND, cafs_pkg::ALU_OR, cafs_pkg::ALU_EOR: begin
			if (i_op == cafs_pkg::ALU_AND) begin
				o_res = i_a & i_b;
			end else if (i_op == cafs_pkg::ALU_OR) begin
				o_res = i_a | i_b;
			end else begin
				o_res = i_a ^ i_b;
			end
			o_flags[cafs_pkg::FL_V] = 1'b0;
			o_mask = cafs_pkg::MASK_LOGIC;
		end
		cafs_pkg::ALU_COM: begin
			o_res = ~i_a;
			o_flags[cafs_pkg::FL_C] = 1'b1;
			o_flags[cafs_pkg::FL_V] = 1'b0;
			o_mask = cafs_pkg::MASK_SHIFT;
		end
		cafs_pkg::ALU_NEG: begin
			o_res = 8'h00 - i_a;
			o_flags[cafs_pkg::FL_C] = (o_res != 8'h00);
			o_flags[cafs_pkg::FL_V] = (o_res == 8'h80);
			o_flags[cafs_pkg::FL_H] = o_res[3] | i_a[3];
			o_mask = cafs_pkg::MASK_ARITH;
		end
		cafs_pkg::ALU_INC, cafs_pkg::ALU_DEC: begin
			if (i_op == cafs_pkg::ALU_INC) begin
				o_res = i_a + 8'h01;
				o_flags[cafs_pkg::FL_V] = (o_res == 8'h80);
			end else begin
				o_res = i_a - 8'h01;
				o_flags[cafs_pkg::FL_V] = (i_a == 8'h80);
			end
			o_mask = cafs_pkg::MASK_INCDEC;
		end
		cafs_pkg::ALU_LSR, cafs_pkg::ALU_ROR, cafs_pkg::ALU_ASR: begin
			if (i_op == cafs_pkg::ALU_LSR) begin
				o_res = {1'b0, i_a[7:1]};
			end else if (i_op == cafs_pkg::ALU_ROR) begin
				o_res = {i_flags[cafs_pkg::FL_C], i_a[7:1]};
			end else begin
				o_res = {i_a[7], i_a[7:1]};
			end
			o_flags[cafs_pkg::FL_C] = i_a[0];
			o_flags[cafs_pkg::FL_V] = o_res[7] ^ i_a[0];
			o_mask = cafs_pkg::MASK_SHIFT;
		end
		cafs_pkg::ALU_SWAP: o_res = {i_a[3:0], i_a[7:4]};
		cafs_pkg::ALU_MOV: o_res = i_b;
		cafs_pkg::ALU_MUL: begin
			o_res = prod[7:0];
			o_res_hi = prod[15:8];
			o_flags[cafs_pkg::FL_C] = prod[15];
			o_mask = cafs_pkg::MASK_MUL;
		end
		cafs_pkg::ALU_BLD: o_res[i_bit] = i_flags[cafs_pkg::FL_T];
		default: ;
		endcase
		zero = (o_res == 8'h00);
		o_flags[cafs_pkg::FL_N] = o_res[7];
		// Carry-chained subtract only keeps zero if all bytes were zero
		if (i_op == cafs_pkg::ALU_SBC) begin
			o_flags[cafs_pkg::FL_Z] = zero & i_flags[cafs_pkg::FL_Z];
		end else if (i_op == cafs_pkg::ALU_MUL) begin
			o_flags[cafs_pkg::FL_Z] = (prod == 16'h0000);
		end else begin
			o_flags[cafs_pkg::FL_Z] = zero;
		end
		o_flags[cafs_pkg::FL_S] = o_flags[cafs_pkg::FL_N] ^
			o_flags[cafs_pkg::FL_V];
		// Single-bit flag operations go last so nothing above overrides them
		case (i_op)
		cafs_pkg::ALU_BST: begin
			o_flags[cafs_pkg::FL_T] = i_a[i_bit];
			o_mask[cafs_pkg::FL_T] = 1'b1;
		end
		cafs_pkg::ALU_FSET: begin
			o_flags[i_bit] = 1'b1;
			o_mask[i_bit] = 1'b1;
		end
		cafs_pkg::ALU_FCLR: begin
			o_flags[i_bit] = 1'b0;
			o_mask[i_bit] = 1'b1;
		end
		default: ;
		endcase
	end

endmodule

// ---- rtl/cafs_core.sv ----
`timescale 1ns/100ps
module cafs_core #(
	parameter int SP_W = cafs_pkg::SP_WIDTH
) (
	// Clock and reset
	input logic i_core_clk,
	input logic i_resetn,
	// ALU command from the decoder
	input logic i_alu_go,
	input logic [4:0] i_alu_op,
	input logic [4:0] i_rd_sel,
	input logic [4:0] i_rr_sel,
	input logic [7:0] i_imm,
	input logic i_use_imm,
	input logic [2:0] i_bit_sel,
	input logic i_wb_en,
	// Pair copy
	input logic i_movw_go,
	input logic [3:0] i_movw_dst,
	input logic [3:0] i_movw_src,
	// Pointer addressing
	input logic i_ptr_go,
	input logic [1:0] i_ptr_sel,
	input logic [1:0] i_ptr_mode,
	input logic [5:0] i_ptr_disp,
	// Data-space access to the registers
	input logic i_ds_re,
	input logic i_ds_we,
	input logic [15:0] i_ds_addr,
	input logic [7:0] i_ds_wdata,
	// I/O space access
	input logic i_io_re,
	input logic i_io_we,
	input logic [5:0] i_io_addr,
	input logic [7:0] i_io_wdata,
	// Stack and interrupt control
	input logic [2:0] i_sp_op,
	input logic i_irq_req,
	input logic i_return_from_irq_op,
	// Results
	output logic [7:0] o_alu_result,
	output logic [7:0] o_flags,
	output logic [SP_W-1:0] o_sp,
	output logic [15:0] o_ptr_addr,
	output logic o_ptr_valid,
	output logic o_ds_hit,
	output logic [7:0] o_ds_rdata,
	output logic [7:0] o_io_rdata,
	// Interrupt handshake
	output logic o_irq_enable,
	output logic o_irq_take
);
	typedef struct packed {
		logic [7:0] flags;
		logic [SP_W-1:0] sp;
		logic [7:0] result;
		logic [7:0] io_rdata;
		logic [7:0] ds_rdata;
		logic [15:0] ptr_addr;
		logic ptr_valid;
	} cafs_core_state_t;

	cafs_core_state_t st_q;
	cafs_core_state_t st_d;

	logic rst_meta_q;
	logic rst_sync_q;

	// Register file ports
	logic [4:0] ra_sel;
	logic [7:0] ra_data;
	logic [7:0] rb_data;
	logic [15:0] rw_data;
	logic [15:0] ptr_x;
	logic [15:0] ptr_y;
	logic [15:0] ptr_z;
	logic w8_en;
	logic [4:0] w8_sel;
	logic [7:0] w8_data;
	logic w16_en;
	logic [3:0] w16_pair;
	logic [15:0] w16_data;

	// ALU ports
	logic [7:0] alu_b;
	logic [7:0] alu_res;
	logic [7:0] alu_res_hi;
	logic [7:0] alu_flags;
	logic [7:0] alu_mask;
	logic alu_is_mul;
	logic cli_now;

	// Pointer path
	logic [15:0] ptr_base;
	logic [15:0] ptr_next;
	logic [15:0] ptr_eff;
	logic [3:0] ptr_pair;
	logic ptr_wb;

	logic ds_hit;
	logic [15:0] sp_wide;

	// Asynchronous assert, synchronous release of reset
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// Data-space reads share the first port while no ALU command runs
	assign ra_sel = i_alu_go ? i_rd_sel : i_ds_addr[4:0];
	assign alu_b = i_use_imm ? i_imm : rb_data;
	assign alu_is_mul = (i_alu_op == cafs_pkg::ALU_MUL);
	assign ds_hit = (i_ds_addr < cafs_pkg::DS_REG_LIMIT);

	cafs_regfile #(
		.NREG(cafs_pkg::NUM_REGS)
	) u_regfile (
		.i_clk(i_core_clk),
		.i_rst_n(rst_sync_q),
		.i_ra_sel(ra_sel),
		.o_ra(ra_data),
		.i_rb_sel(i_rr_sel),
		.o_rb(rb_data),
		.i_rw_pair(i_movw_src),
		.o_rw(rw_data),
		.o_ptr_x(ptr_x),
		.o_ptr_y(ptr_y),
		.o_ptr_z(ptr_z),
		.i_w8_en(w8_en),
		.i_w8_sel(w8_sel),
		.i_w8_data(w8_data),
		.i_w16_en(w16_en),
		.i_w16_pair(w16_pair),
		.i_w16_data(w16_data)
	);

	cafs_alu u_alu (
		.i_op(i_alu_op),
		.i_bit(i_bit_sel),
		.i_a(ra_data),
		.i_b(alu_b),
		.i_flags(st_q.flags),
		.o_res(alu_res),
		.o_res_hi(alu_res_hi),
		.o_flags(alu_flags),
		.o_mask(alu_mask)
	);

	// Pointer selection and address arithmetic
	always_comb begin
		case (i_ptr_sel)
		2'h0: begin
			ptr_base = ptr_x;
			ptr_pair = cafs_pkg::PAIR_X;
		end
		2'h1: begin
			ptr_base = ptr_y;
			ptr_pair = cafs_pkg::PAIR_Y;
		end
		default: begin
			ptr_base = ptr_z;
			ptr_pair = cafs_pkg::PAIR_Z;
		end
		endcase
		ptr_next = ptr_base;
		ptr_eff = ptr_base;
		ptr_wb = 1'b0;
		case (i_ptr_mode)
		cafs_pkg::PM_POSTINC: begin
			ptr_next = ptr_base + cafs_pkg::PTR_STEP;
			ptr_wb = 1'b1;
		end
		cafs_pkg::PM_PREDEC: begin
			ptr_next = ptr_base - cafs_pkg::PTR_STEP;
			ptr_eff = ptr_next;
			ptr_wb = 1'b1;
		end
		cafs_pkg::PM_DISP: ptr_eff = ptr_base + {10'h000, i_ptr_disp};
		default: ;
		endcase
	end

	// Write-back steering; commands are exclusive, priorities break ties
	always_comb begin
		w8_en = 1'b0;
		w8_sel = i_rd_sel;
		w8_data = alu_res;
		if (i_alu_go && i_wb_en && !alu_is_mul) begin
			w8_en = 1'b1;
		end else if (i_ds_we && ds_hit) begin
			w8_en = 1'b1;
			w8_sel = i_ds_addr[4:0];
			w8_data = i_ds_wdata;
		end
		w16_en = 1'b0;
		w16_pair = cafs_pkg::PAIR_PROD;
		w16_data = {alu_res_hi, alu_res};
		if (i_ptr_go && ptr_wb) begin
			w16_en = 1'b1;
			w16_pair = ptr_pair;
			w16_data = ptr_next;
		end else if (i_movw_go) begin
			w16_en = 1'b1;
			w16_pair = i_movw_dst;
			w16_data = rw_data;
		end else if (i_alu_go && i_wb_en && alu_is_mul) begin
			w16_en = 1'b1;
		end
	end

	// A clear of the gate in this very cycle already blocks the request
	assign cli_now = i_alu_go && (i_alu_op == cafs_pkg::ALU_FCLR) &&
		(i_bit_sel == 3'(cafs_pkg::FL_I));
	assign o_irq_take = i_irq_req && st_q.flags[cafs_pkg::FL_I] &&
		!cli_now;
	assign o_irq_enable = st_q.flags[cafs_pkg::FL_I];

	assign sp_wide = 16'(st_q.sp);

	always_comb begin
		logic [7:0] fl;
		logic [15:0] sp;
		fl = st_q.flags;
		sp = sp_wide;
		st_d = st_q;

		// Software writes through I/O; no automatic save on interrupts
		if (i_io_we) begin
			case (i_io_addr)
			cafs_pkg::IO_FLAGS: fl = i_io_wdata;
			cafs_pkg::IO_SP_LOW: sp[7:0] = i_io_wdata;
			cafs_pkg::IO_SP_HIGH: sp[15:8] = i_io_wdata;
			default: ;
			endcase
		end

		if (i_alu_go) begin
			fl = (fl & ~alu_mask) | (alu_flags & alu_mask);
			st_d.result = alu_res;
		end

		// Entry and return move the stack by a full return address
		if (o_irq_take) begin
			fl[cafs_pkg::FL_I] = 1'b0;
			sp = sp - cafs_pkg::SP_STEP_ADDR;
		end else if (i_return_from_irq_op) begin
			fl[cafs_pkg::FL_I] = 1'b1;
			sp = sp + cafs_pkg::SP_STEP_ADDR;
		end else begin
			case (i_sp_op)
			cafs_pkg::SP_PUSH1: sp = sp - cafs_pkg::SP_STEP_BYTE;
			cafs_pkg::SP_PUSH2: sp = sp - cafs_pkg::SP_STEP_ADDR;
			cafs_pkg::SP_POP1: sp = sp + cafs_pkg::SP_STEP_BYTE;
			cafs_pkg::SP_POP2: sp = sp + cafs_pkg::SP_STEP_ADDR;
			default: ;
			endcase
		end

		// Sign is derived, never stored independently
		fl[cafs_pkg::FL_S] = fl[cafs_pkg::FL_N] ^ fl[cafs_pkg::FL_V];
		st_d.flags = fl;
		st_d.sp = sp[SP_W-1:0];

		if (i_io_re) begin
			case (i_io_addr)
			cafs_pkg::IO_FLAGS: st_d.io_rdata = st_q.flags;
			cafs_pkg::IO_SP_LOW: st_d.io_rdata = sp_wide[7:0];
			cafs_pkg::IO_SP_HIGH: st_d.io_rdata = sp_wide[15:8];
			default: st_d.io_rdata = 8'h00;
			endcase
		end

		// Reads outside the register window return zero
		if (i_ds_re) begin
			st_d.ds_rdata = ds_hit ? ra_data : 8'h00;
		end

		st_d.ptr_valid = i_ptr_go;
		if (i_ptr_go) begin
			st_d.ptr_addr = ptr_eff;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			st_q.flags <= cafs_pkg::FLAGS_RST;
			st_q.sp <= cafs_pkg::SP_RST[SP_W-1:0];
			st_q.result <= 8'h00;
			st_q.io_rdata <= 8'h00;
			st_q.ds_rdata <= 8'h00;
			st_q.ptr_addr <= 16'h0000;
			st_q.ptr_valid <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_alu_result = st_q.result;
	assign o_flags = st_q.flags;
	assign o_sp = st_q.sp;
	assign o_ptr_addr = st_q.ptr_addr;
	assign o_ptr_valid = st_q.ptr_valid;
	assign o_ds_hit = ds_hit;
	assign o_ds_rdata = st_q.ds_rdata;
	assign o_io_rdata = st_q.io_rdata;

endmodule

// ---- rtl/cafs_pkg.sv ----
package cafs_pkg;

	localparam int NUM_REGS = 32;
	localparam int SP_WIDTH = 16;

	// Flag bit positions
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_V = 3;
	localparam int FL_S = 4;
	localparam int FL_H = 5;
	localparam int FL_T = 6;
	localparam int FL_I = 7;

	// Flag groups touched by operation classes
	localparam logic [7:0] MASK_ARITH = 8'h3f;
	localparam logic [7:0] MASK_LOGIC = 8'h1e;
	localparam logic [7:0] MASK_SHIFT = 8'h1f;
	localparam logic [7:0] MASK_INCDEC = 8'h1e;
	localparam logic [7:0] MASK_MUL = 8'h03;

	// Reset values
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [15:0] SP_RST = 16'h0000;

	// I/O space locations
	localparam logic [5:0] IO_SP_LOW = 6'h3d;
	localparam logic [5:0] IO_SP_HIGH = 6'h3e;
	localparam logic [5:0] IO_FLAGS = 6'h3f;

	// Data space: registers occupy addresses below this
	localparam logic [15:0] DS_REG_LIMIT = 16'h0020;

	// Register pairs: pointers and the wide product target
	localparam logic [3:0] PAIR_X = 4'hd;
	localparam logic [3:0] PAIR_Y = 4'he;
	localparam logic [3:0] PAIR_Z = 4'hf;
	localparam logic [3:0] PAIR_PROD = 4'h0;

	// Stack and pointer steps
	localparam logic [15:0] SP_STEP_BYTE = 16'h0001;
	localparam logic [15:0] SP_STEP_ADDR = 16'h0002;
	localparam logic [15:0] PTR_STEP = 16'h0001;

	typedef enum logic [4:0] {
		ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_EOR,
		ALU_COM, ALU_NEG, ALU_INC, ALU_DEC, ALU_LSR, ALU_ROR, ALU_ASR,
		ALU_SWAP, ALU_MOV, ALU_MUL, ALU_BST, ALU_BLD, ALU_FSET, ALU_FCLR
	} alu_op_t;

	typedef enum logic [1:0] {
		PM_PLAIN, PM_POSTINC, PM_PREDEC, PM_DISP
	} ptr_mode_t;

	typedef enum logic [2:0] {
		SP_NONE, SP_PUSH1, SP_PUSH2, SP_POP1, SP_POP2
	} sp_op_t;

endpackage

// ---- rtl/cafs_regfile.sv ----
`timescale 1ns/100ps
module cafs_regfile #(
	parameter int NREG = cafs_pkg::NUM_REGS
) (
	// Clock and reset
	input logic i_clk,
	input logic i_rst_n,
	// Byte read ports
	input logic [4:0] i_ra_sel,
	output logic [7:0] o_ra,
	input logic [4:0] i_rb_sel,
	output logic [7:0] o_rb,
	// Pair read port
	input logic [3:0] i_rw_pair,
	output logic [15:0] o_rw,
	// Pointer views
	output logic [15:0] o_ptr_x,
	output logic [15:0] o_ptr_y,
	output logic [15:0] o_ptr_z,
	// Byte write port
	input logic i_w8_en,
	input logic [4:0] i_w8_sel,
	input logic [7:0] i_w8_data,
	// Pair write port
	input logic i_w16_en,
	input logic [3:0] i_w16_pair,
	input logic [15:0] i_w16_data
);
	typedef struct packed {
		logic [NREG-1:0][7:0] regs;
	} cafs_rf_state_t;

	cafs_rf_state_t st_q;
	cafs_rf_state_t st_d;

	assign o_ra = st_q.regs[i_ra_sel];
	assign o_rb = st_q.regs[i_rb_sel];
	assign o_rw = {st_q.regs[{i_rw_pair, 1'b1}], st_q.regs[{i_rw_pair, 1'b0}]};
	// Upper pairs double as address pointers, low byte at even index
	assign o_ptr_x = {st_q.regs[{cafs_pkg::PAIR_X, 1'b1}],
		st_q.regs[{cafs_pkg::PAIR_X, 1'b0}]};
	assign o_ptr_y = {st_q.regs[{cafs_pkg::PAIR_Y, 1'b1}],
		st_q.regs[{cafs_pkg::PAIR_Y, 1'b0}]};
	assign o_ptr_z = {st_q.regs[{cafs_pkg::PAIR_Z, 1'b1}],
		st_q.regs[{cafs_pkg::PAIR_Z, 1'b0}]};

	always_comb begin
		st_d = st_q;
		if (i_w8_en) begin
			st_d.regs[i_w8_sel] = i_w8_data;
		end
		// Pair write last: it wins if both target the same byte
		if (i_w16_en) begin
			st_d.regs[{i_w16_pair, 1'b1}] = i_w16_data[15:8];
			st_d.regs[{i_w16_pair, 1'b0}] = i_w16_data[7:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

endmodule

// ---- tb/cafs_core_chk.sv ----
`timescale 1ns/100ps
module cafs_core_chk #(
	parameter int SP_W = 16
) (
	// Clock and reset
	input logic i_core_clk,
	input logic i_resetn,
	// Watched inputs
	input logic i_alu_go,
	input logic [4:0] i_alu_op,
	input logic [2:0] i_bit_sel,
	input logic i_io_we,
	input logic [2:0] i_sp_op,
	input logic i_irq_req,
	input logic i_return_from_irq_op,
	input logic i_ptr_go,
	input logic [15:0] i_ds_addr,
	// Watched outputs
	input logic [7:0] o_flags,
	input logic [SP_W-1:0] o_sp,
	input logic o_ptr_valid,
	input logic o_ds_hit,
	input logic o_irq_enable,
	input logic o_irq_take
);
	logic quiet;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_resetn);

	// Higher-priority stack movers are left out so each check sees one cause
	assign quiet = !o_irq_take && !i_return_from_irq_op && !i_io_we;

	chk_sp_push_one: assert property (quiet && i_sp_op == 3'h1 |=>
		o_sp == SP_W'($past(o_sp) - 1)) else $error("push1 step wrong");
	chk_sp_push_two: assert property (quiet && i_sp_op == 3'h2 |=>
		o_sp == SP_W'($past(o_sp) - 2)) else $error("push2 step wrong");
	chk_sp_pop_one: assert property (quiet && i_sp_op == 3'h3 |=>
		o_sp == SP_W'($past(o_sp) + 1)) else $error("pop1 step wrong");
	chk_sp_pop_two: assert property (quiet && i_sp_op == 3'h4 |=>
		o_sp == SP_W'($past(o_sp) + 2)) else $error("pop2 step wrong");
	chk_irq_entry: assert property (o_irq_take && !i_io_we |=>
		!o_irq_enable && o_sp == SP_W'($past(o_sp) - 2))
		else $error("irq entry wrong");
	chk_irq_return: assert property (
		i_return_from_irq_op && !o_irq_take && !i_io_we && !i_alu_go |=>
		o_irq_enable && o_sp == SP_W'($past(o_sp) + 2))
		else $error("irq return wrong");
	chk_irq_gated: assert property (o_irq_take |->
		i_irq_req && o_irq_enable) else $error("irq taken while gated");
	chk_irq_open: assert property (
		i_irq_req && o_irq_enable && !i_alu_go |-> o_irq_take)
		else $error("irq not taken");
	chk_sign_xor: assert property (
		o_flags[4] == (o_flags[2] ^ o_flags[3])) else $error("sign bit");
	chk_gate_flag: assert property (
		o_irq_enable == o_flags[7]) else $error("enable not flag bit");
	chk_flags_hold: assert property (
		!i_alu_go && !i_io_we && !o_irq_take && !i_return_from_irq_op |=> $stable(o_flags))
		else $error("flags moved");
	chk_ds_window: assert property (
		o_ds_hit == (i_ds_addr < 16'h0020)) else $error("ds hit wrong");
	chk_ptr_pulse: assert property (i_ptr_go |=> o_ptr_valid)
		else $error("pointer valid missing");
	chk_cli_gate: assert property (
		i_alu_go && i_alu_op == cafs_pkg::ALU_FCLR && i_bit_sel == 3'h7
		|-> !o_irq_take ##1 !o_irq_enable) else $error("clear did not gate");
endmodule

bind cafs_core cafs_core_chk #(.SP_W(SP_W)) u_chk (
	.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_alu_go(i_alu_go),
	.i_alu_op(i_alu_op), .i_bit_sel(i_bit_sel),
	.i_io_we(i_io_we), .i_sp_op(i_sp_op), .i_irq_req(i_irq_req),
	.i_return_from_irq_op(i_return_from_irq_op), .i_ptr_go(i_ptr_go), .i_ds_addr(i_ds_addr),
	.o_flags(o_flags), .o_sp(o_sp), .o_ptr_valid(o_ptr_valid),
	.o_ds_hit(o_ds_hit), .o_irq_enable(o_irq_enable),
	.o_irq_take(o_irq_take)
);

// ---- tb/cafs_mem_model.sv ----
`timescale 1ns/100ps
module cafs_mem_model (
	// Pointer bus from the core
	input logic i_clk,
	input logic [15:0] i_addr,
	input logic i_valid,
	// Last address served
	output logic [15:0] o_last
);
	// Only valid cycles are logged, so a stale address is never served
	always @(posedge i_clk) begin
		if (i_valid) begin
			o_last <= i_addr;
		end
	end
endmodule

// ---- tb/tb_cafs_core.sv ----
`timescale 1ns/100ps
module tb_cafs_core;
	logic i_core_clk = 1'b0, i_resetn = 1'b0;
	logic i_alu_go = 1'b0, i_use_imm = 1'b0, i_wb_en = 1'b0;
	logic [4:0] i_alu_op = 5'h00, i_rd_sel = 5'h00, i_rr_sel = 5'h00;
	logic [7:0] i_imm = 8'h00, i_ds_wdata = 8'h00, i_io_wdata = 8'h00;
	logic [2:0] i_bit_sel = 3'h0, i_sp_op = 3'h0;
	logic i_ptr_go = 1'b0, i_ds_re = 1'b0, i_ds_we = 1'b0;
	logic i_movw_go = 1'b0;
	logic [3:0] i_movw_dst = 4'h0, i_movw_src = 4'h0;
	logic i_io_re = 1'b0, i_io_we = 1'b0, i_irq_req = 1'b0, i_return_from_irq_op = 1'b0;
	logic [1:0] i_ptr_sel = 2'h0, i_ptr_mode = 2'h0;
	logic [5:0] i_ptr_disp = 6'h00, i_io_addr = 6'h00;
	logic [15:0] i_ds_addr = 16'h0000;
	logic [7:0] o_alu_result, o_flags, o_ds_rdata, o_io_rdata;
	logic [15:0] o_sp, o_ptr_addr, mem_last;
	logic o_ptr_valid, o_ds_hit, o_irq_enable, o_irq_take;
	int bad_count = 0;
	int n_compared = 0;

	always #5 i_core_clk = ~i_core_clk;

	cafs_core dut (
		.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_alu_go(i_alu_go),
		.i_alu_op(i_alu_op), .i_rd_sel(i_rd_sel), .i_rr_sel(i_rr_sel),
		.i_imm(i_imm), .i_use_imm(i_use_imm), .i_bit_sel(i_bit_sel),
		.i_wb_en(i_wb_en), .i_movw_go(i_movw_go),
		.i_movw_dst(i_movw_dst), .i_movw_src(i_movw_src),
		.i_ptr_go(i_ptr_go), .i_ptr_sel(i_ptr_sel),
		.i_ptr_mode(i_ptr_mode), .i_ptr_disp(i_ptr_disp), .i_ds_re(i_ds_re),
		.i_ds_we(i_ds_we), .i_ds_addr(i_ds_addr), .i_ds_wdata(i_ds_wdata),
		.i_io_re(i_io_re), .i_io_we(i_io_we), .i_io_addr(i_io_addr),
		.i_io_wdata(i_io_wdata), .i_sp_op(i_sp_op), .i_irq_req(i_irq_req),
		.i_return_from_irq_op(i_return_from_irq_op), .o_alu_result(o_alu_result), .o_flags(o_flags),
		.o_sp(o_sp), .o_ptr_addr(o_ptr_addr), .o_ptr_valid(o_ptr_valid),
		.o_ds_hit(o_ds_hit), .o_ds_rdata(o_ds_rdata),
		.o_io_rdata(o_io_rdata), .o_irq_enable(o_irq_enable),
		.o_irq_take(o_irq_take)
	);

	cafs_mem_model u_mem (.i_clk(i_core_clk), .i_addr(o_ptr_addr),
		.i_valid(o_ptr_valid), .o_last(mem_last));

	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic step;
		@(negedge i_core_clk);
	endtask

	// Each command owns two cycles so no strobe is raised twice in a step
	task automatic alu(input logic [4:0] op, input logic [4:0] rd,
		input logic [7:0] b, input logic imm, input logic [2:0] bs,
		input logic wb);
		i_alu_op = op;
		i_rd_sel = rd;
		i_rr_sel = b[4:0];
		i_imm = b;
		i_use_imm = imm;
		i_bit_sel = bs;
		i_wb_en = wb;
		i_alu_go = 1'b1;
		step;
		i_alu_go = 1'b0;
		step;
	endtask

	task automatic ds(input logic we, input logic [15:0] a,
		input logic [7:0] d);
		i_ds_addr = a;
		i_ds_wdata = d;
		i_ds_we = we;
		i_ds_re = !we;
		step;
		i_ds_we = 1'b0;
		i_ds_re = 1'b0;
		step;
	endtask

	task automatic io(input logic we, input logic [5:0] a,
		input logic [7:0] d);
		i_io_addr = a;
		i_io_wdata = d;
		i_io_we = we;
		i_io_re = !we;
		step;
		i_io_we = 1'b0;
		i_io_re = 1'b0;
		step;
	endtask

	task automatic sp_check(input logic [2:0] op, input logic [15:0] exp);
		i_sp_op = op;
		step;
		i_sp_op = 3'h0;
		step;
		check("stack pointer", o_sp, exp);
	endtask

	task automatic ptr(input logic [1:0] s, input logic [1:0] m,
		input logic [5:0] d, input logic [15:0] exp);
		i_ptr_sel = s;
		i_ptr_mode = m;
		i_ptr_disp = d;
		i_ptr_go = 1'b1;
		step;
		i_ptr_go = 1'b0;
		check("ptr addr", o_ptr_addr, exp);
		check("ptr valid", o_ptr_valid, 16'h0001);
		step;
		check("mem addr", mem_last, exp);
	endtask

	task automatic t_reset;
		check("flags", o_flags, 16'h0000);
		check("sp", o_sp, 16'h0000);
		io(1'b0, 6'h3e, 8'h00);
		check("sp high", o_io_rdata, 16'h0000);
	endtask

	task automatic t_stack;
		io(1'b1, 6'h3e, 8'h02);
		io(1'b1, 6'h3d, 8'h00);
		check("sp written", o_sp, 16'h0200);
		io(1'b0, 6'h3e, 8'h00);
		check("sp high rd", o_io_rdata, 16'h0002);
		sp_check(3'h1, 16'h01ff);
		sp_check(3'h2, 16'h01fd);
		sp_check(3'h3, 16'h01fe);
		sp_check(3'h4, 16'h0200);
	endtask

	task automatic t_arith;
		ds(1'b1, 16'h0001, 8'h7f);
		ds(1'b1, 16'h0002, 8'h01);
		alu(cafs_pkg::ALU_ADD, 5'h01, 8'h02, 1'b0, 3'h0, 1'b1);
		check("add res", o_alu_result, 16'h0080);
		check("add flags", o_flags, 16'h002c);
		ds(1'b0, 16'h0001, 8'h00);
		check("r1", o_ds_rdata, 16'h0080);
		alu(cafs_pkg::ALU_SUB, 5'h01, 8'h80, 1'b1, 3'h0, 1'b0);
		check("sub flags", o_flags, 16'h0002);
		alu(cafs_pkg::ALU_ADD, 5'h01, 8'h80, 1'b1, 3'h0, 1'b0);
		check("carry flags", o_flags, 16'h001b);
	endtask

	task automatic t_bits;
		alu(cafs_pkg::ALU_AND, 5'h01, 8'h0f, 1'b1, 3'h0, 1'b0);
		check("and flags", o_flags, 16'h0003);
		alu(cafs_pkg::ALU_BST, 5'h01, 8'h00, 1'b0, 3'h7, 1'b0);
		check("store bit", o_flags, 16'h0043);
		alu(cafs_pkg::ALU_BLD, 5'h02, 8'h00, 1'b0, 3'h3, 1'b1);
		ds(1'b0, 16'h0002, 8'h00);
		check("load bit", o_ds_rdata, 16'h0009);
		alu(cafs_pkg::ALU_FSET, 5'h00, 8'h00, 1'b0, 3'h7, 1'b0);
		check("irq on", o_irq_enable, 16'h0001);
	endtask

	task automatic t_irq;
		io(1'b0, 6'h3f, 8'h00);
		check("flags rd", o_io_rdata, 16'h00c3);
		i_irq_req = 1'b1;
		#1;
		check("take", o_irq_take, 16'h0001);
		step;
		check("entry gate", o_irq_enable, 16'h0000);
		check("entry sp", o_sp, 16'h01fe);
		check("entry flags", o_flags, 16'h0043);
		// Request still high here: the cleared gate alone must block it
		check("gated", o_irq_take, 16'h0000);
		i_irq_req = 1'b0;
		step;
		i_return_from_irq_op = 1'b1;
		step;
		i_return_from_irq_op = 1'b0;
		check("return sp", o_sp, 16'h0200);
		check("return flags", o_flags, 16'h00c3);
		i_irq_req = 1'b1;
		alu(cafs_pkg::ALU_FCLR, 5'h00, 8'h00, 1'b0, 3'h7, 1'b0);
		i_irq_req = 1'b0;
		check("irq off", o_flags, 16'h0043);
		check("no entry", o_sp, 16'h0200);
	endtask

	task automatic t_ptr;
		ds(1'b1, 16'h001a, 8'h10);
		ds(1'b1, 16'h001b, 8'h00);
		ds(1'b1, 16'h001c, 8'h20);
		ds(1'b1, 16'h001d, 8'h01);
		ptr(2'h0, 2'h1, 6'h00, 16'h0010);
		ds(1'b0, 16'h001a, 8'h00);
		check("x inc", o_ds_rdata, 16'h0011);
		ptr(2'h0, 2'h2, 6'h00, 16'h0010);
		ds(1'b0, 16'h001a, 8'h00);
		check("x dec", o_ds_rdata, 16'h0010);
		ptr(2'h1, 2'h3, 6'h05, 16'h0125);
		ds(1'b1, 16'h0000, 8'h55);
		ds(1'b1, 16'h0020, 8'haa);
		ds(1'b0, 16'h0020, 8'h00);
		check("beyond regs", o_ds_rdata, 16'h0000);
		check("hit", o_ds_hit, 16'h0000);
		ds(1'b0, 16'h0000, 8'h00);
		check("r0 kept", o_ds_rdata, 16'h0055);
		check("hit low", o_ds_hit, 16'h0001);
	endtask

	task automatic t_pair;
		alu(cafs_pkg::ALU_MUL, 5'h1c, 8'h1a, 1'b0, 3'h0, 1'b1);
		check("mul flags", o_flags, 16'h0040);
		ds(1'b0, 16'h0001, 8'h00);
		check("mul high", o_ds_rdata, 16'h0002);
		i_movw_dst = 4'h1;
		i_movw_src = 4'he;
		i_movw_go = 1'b1;
		step;
		i_movw_go = 1'b0;
		step;
		ds(1'b0, 16'h0002, 8'h00);
		check("copy low", o_ds_rdata, 16'h0020);
		ds(1'b0, 16'h0003, 8'h00);
		check("copy high", o_ds_rdata, 16'h0001);
	endtask

	task automatic t_rst2;
		io(1'b1, 6'h3f, 8'h04);
		check("flags wr", o_flags, 16'h0014);
		i_resetn = 1'b0;
		step;
		check("rst gate", o_irq_enable, 16'h0000);
		check("rst sp", o_sp, 16'h0000);
		i_resetn = 1'b1;
		repeat (4) step;
		ds(1'b0, 16'h0001, 8'h00);
		check("rst regs", o_ds_rdata, 16'h0000);
	endtask

	task automatic stop_test;
		if (bad_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20) step;
		i_resetn = 1'b1;
		repeat (4) step;
		t_reset;
		t_stack;
		t_arith;
		t_bits;
		t_irq;
		t_ptr;
		t_pair;
		t_rst2;
		stop_test;
	end
endmodule
